// ---- hw/sfe_map.svh ----
// Register map, opcodes and bit counts of the flash command front end
`ifndef SFE_MAP_SVH
`define SFE_MAP_SVH
// ========
// Register byte offsets and fields
`define SFE_OFS_CTRL 4'h0
`define SFE_OFS_UPPER 4'h4
`define SFE_OFS_STATUS 4'h8
`define SFE_CTRL_BUSY 0
`define SFE_CTRL_OTP 1
`define SFE_UPPER_SEG 0
`define SFE_ST_WIDE 0
`define SFE_ST_QUAD 1
`define SFE_ST_ACTIVE 2
`define SFE_ST_STANDBY 3
`define SFE_ST_OPC 15:8
// ========
// Reset values
`define SFE_RST_UPPER 1'h0
`define SFE_RST_WIDE 1'h0
`define SFE_RST_QUAD 1'h0
`define SFE_RST_PINS 6'h20
// ========
// Address layout and bit counts
`define SFE_SEG_LSB 24
`define SFE_BITS_OPC 6'h08
`define SFE_BITS_ADDR3 6'h18
`define SFE_BITS_ADDR4 6'h20
`define SFE_DUMMY_FAST 4'h8
`define SFE_DUMMY_DUAL_IO 4'h4
`define SFE_DUMMY_QUAD_IO 4'h6
`define SFE_OE_X1 4'h2
`define SFE_OE_X2 4'h3
`define SFE_OE_X4 4'hf
// ========
// Opcodes
`define SFE_OP_READ 8'h03
`define SFE_OP_READ4 8'h13
`define SFE_OP_FAST 8'h0b
`define SFE_OP_FAST4 8'h0c
`define SFE_OP_DUAL_IO 8'hbb
`define SFE_OP_DUAL_IO4 8'hbc
`define SFE_OP_DUAL_OUT 8'h3b
`define SFE_OP_DUAL_OUT4 8'h3c
`define SFE_OP_QUAD_OUT 8'h6b
`define SFE_OP_QUAD_OUT4 8'h6c
`define SFE_OP_QUAD_IO 8'heb
`define SFE_OP_QUAD_IO_TOP 8'hea
`define SFE_OP_QUAD_IO4 8'hec
`define SFE_OP_WR_ENABLE 8'h06
`define SFE_OP_WR_DISABLE 8'h04
`define SFE_OP_STATUS_WRITE 8'h01
`define SFE_OP_PAGE_PROG 8'h02
`define SFE_OP_PAGE_PROG4 8'h12
`define SFE_OP_QUAD_PROG 8'h38
`define SFE_OP_QUAD_PROG4 8'h3e
`define SFE_OP_SECTOR_ERASE 8'h20
`define SFE_OP_SECTOR_ERASE4 8'h21
`define SFE_OP_BLK32_ERASE 8'h52
`define SFE_OP_BLK32_ERASE4 8'h5c
`define SFE_OP_BLK_ERASE 8'hd8
`define SFE_OP_BLK_ERASE4 8'hdc
`define SFE_OP_CHIP_ERASE 8'h60
`define SFE_OP_CHIP_ERASE_ALT 8'hc7
`define SFE_OP_ENTER_WIDE 8'hb7
`define SFE_OP_EXIT_WIDE 8'he9
`define SFE_OP_ENTER_FOUR_LINE 8'h35
`define SFE_OP_LEAVE_FOUR_LINE 8'hf5
`endif

// ---- hw/sfe_pkg.sv ----
// Types shared by the flash command front end
package sfe_pkg;
  // ========
  // Link states
  typedef enum logic [2:0] {
    ST_IDLE, ST_OPC, ST_ADDR, ST_DUMMY, ST_RDATA, ST_WDATA, ST_STANDBY
  } sfe_state_type;
  // Command classes and address modes
  typedef enum logic [1:0] {K_BAD, K_READ, K_CTRL} sfe_kind_type;
  typedef enum logic [1:0] {AM_NONE, AM_SHORT, AM_LONG, AM_CFG}
    sfe_amode_type;
  // ========
  // Decoded opcode
  typedef struct packed {
    sfe_kind_type kind;
    sfe_amode_type amode;
    logic [2:0] addr_w;
    logic [2:0] data_w;
    logic [3:0] dummy;
    logic top;
    logic full_erase;
  } sfe_dec_type;
  // Command handed to the array core
  typedef struct packed {
    logic [7:0] opcode;
    logic [31:0] addr;
    logic full_erase;
  } sfe_cmd_type;
endpackage : sfe_pkg

// ---- hw/sfe_sync.sv ----
// Two-flop synchroniser for pin inputs
module sfe_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  if (WIDTH < 1) begin : g_chk
    $error("sfe_sync needs WIDTH of at least one");
  end

  // First stage feeds only the second
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : sfe_sync

// ---- hw/sfe_front_end.sv ----
// Serial flash command and address front end with Avalon-MM registers
// What this block does
// - Bad opcode: standby, outputs released till select
// - Good opcode: active until select rises
// - Sample on clock rise, launch on fall
// - Works with clock idling low or high
// - Reads may end after any bit
// - Control commands run only on byte boundary
// - Array reads ignored while operation busy
// - Enter-wide command sets flag, 32-bit addresses
// - Exit-wide command clears flag, three bytes
// - Wide mode ignores upper address bit
// - Four-byte opcodes always take four bytes
// - Upper register: bit 0 only, resets zero
// - Upper bit selects segment in three-byte mode
// - Continuous read crosses segment, register unchanged
// - Three-byte random reads stay in segment
// - Chip erase covers whole array
// - Opcode 35h enters four-line mode
// - Opcode F5h leaves four-line mode
// - Four-line mode: all phases on four lines
// - Read opcodes other than Quad I/O refused in four-line mode
// - Quad I/O reads in both modes
// - Secure OTP mode blocks array reads
`include "sfe_map.svh"
module sfe_front_end import sfe_pkg::*; #(
  parameter int ADDR_W = 25
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Flash link pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] quad_io_lines_in,
  output logic [3:0] quad_io_lines_out,
  output logic [3:0] quad_io_lines_oe,
  // Avalon-MM register slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Array read port
  output logic [ADDR_W-1:0] rd_addr,
  output logic rd_en,
  input wire logic [7:0] rd_data,
  // Command port to the array core
  output logic cmd_valid,
  output sfe_cmd_type cmd
);
  if (ADDR_W < 25 || ADDR_W > 32) begin : g_chk
    $error("sfe_front_end needs ADDR_W from 25 to 32");
  end

  // ========
  // Opcode decode
  function automatic sfe_dec_type sfe_rd(input logic ok,
      input sfe_amode_type am, input logic [2:0] aw,
      input logic [2:0] dw, input logic [3:0] dm);
    sfe_dec_type d;
    d.kind = ok ? K_READ : K_BAD;
    d.amode = am;
    d.addr_w = aw;
    d.data_w = dw;
    d.dummy = dm;
    d.top = 1'b0;
    d.full_erase = 1'b0;
    return d;
  endfunction : sfe_rd

  function automatic sfe_dec_type sfe_ctl(input logic ok,
      input sfe_amode_type am, input logic [2:0] dw);
    sfe_dec_type d;
    d = sfe_rd(1'b1, am, 3'h1, dw, 4'h0);
    d.kind = ok ? K_CTRL : K_BAD;
    return d;
  endfunction : sfe_ctl

  function automatic sfe_dec_type sfe_decode(input logic [7:0] op,
      input logic quad);
    sfe_dec_type d;
    d = sfe_ctl(1'b0, AM_NONE, 3'h1);
    case (op)
      `SFE_OP_READ: d = sfe_rd(!quad, AM_CFG, 3'h1, 3'h1, 4'h0);
      `SFE_OP_READ4: d = sfe_rd(!quad, AM_LONG, 3'h1, 3'h1, 4'h0);
      `SFE_OP_FAST:
        d = sfe_rd(!quad, AM_CFG, 3'h1, 3'h1, `SFE_DUMMY_FAST);
      `SFE_OP_FAST4:
        d = sfe_rd(!quad, AM_LONG, 3'h1, 3'h1, `SFE_DUMMY_FAST);
      `SFE_OP_DUAL_IO:
        d = sfe_rd(!quad, AM_CFG, 3'h2, 3'h2, `SFE_DUMMY_DUAL_IO);
      `SFE_OP_DUAL_IO4:
        d = sfe_rd(!quad, AM_LONG, 3'h2, 3'h2, `SFE_DUMMY_DUAL_IO);
      `SFE_OP_DUAL_OUT:
        d = sfe_rd(!quad, AM_CFG, 3'h1, 3'h2, `SFE_DUMMY_FAST);
      `SFE_OP_DUAL_OUT4:
        d = sfe_rd(!quad, AM_LONG, 3'h1, 3'h2, `SFE_DUMMY_FAST);
      `SFE_OP_QUAD_OUT:
        d = sfe_rd(!quad, AM_CFG, 3'h1, 3'h4, `SFE_DUMMY_FAST);
      `SFE_OP_QUAD_OUT4:
        d = sfe_rd(!quad, AM_LONG, 3'h1, 3'h4, `SFE_DUMMY_FAST);
      `SFE_OP_QUAD_IO:
        d = sfe_rd(1'b1, AM_CFG, 3'h4, 3'h4, `SFE_DUMMY_QUAD_IO);
      `SFE_OP_QUAD_IO4:
        d = sfe_rd(1'b1, AM_LONG, 3'h4, 3'h4, `SFE_DUMMY_QUAD_IO);
      `SFE_OP_QUAD_IO_TOP: begin
        d = sfe_rd(1'b1, AM_SHORT, 3'h4, 3'h4, `SFE_DUMMY_QUAD_IO);
        d.top = 1'b1;
      end
      `SFE_OP_WR_ENABLE, `SFE_OP_WR_DISABLE, `SFE_OP_STATUS_WRITE,
      `SFE_OP_ENTER_WIDE, `SFE_OP_EXIT_WIDE,
      `SFE_OP_ENTER_FOUR_LINE, `SFE_OP_LEAVE_FOUR_LINE:
        d = sfe_ctl(1'b1, AM_NONE, 3'h1);
      `SFE_OP_CHIP_ERASE, `SFE_OP_CHIP_ERASE_ALT: begin
        d = sfe_ctl(1'b1, AM_NONE, 3'h1);
        d.full_erase = 1'b1;
      end
      `SFE_OP_PAGE_PROG, `SFE_OP_SECTOR_ERASE, `SFE_OP_BLK32_ERASE,
      `SFE_OP_BLK_ERASE:
        d = sfe_ctl(1'b1, AM_CFG, 3'h1);
      `SFE_OP_PAGE_PROG4, `SFE_OP_SECTOR_ERASE4, `SFE_OP_BLK32_ERASE4,
      `SFE_OP_BLK_ERASE4:
        d = sfe_ctl(1'b1, AM_LONG, 3'h1);
      `SFE_OP_QUAD_PROG: d = sfe_ctl(!quad, AM_CFG, 3'h4);
      `SFE_OP_QUAD_PROG4: d = sfe_ctl(!quad, AM_LONG, 3'h4);
      default: d = sfe_ctl(1'b0, AM_NONE, 3'h1);
    endcase
    return d;
  endfunction : sfe_decode

  // Shift in one, two or four bits
  function automatic logic [31:0] sfe_shift(input logic [31:0] sh,
      input logic [3:0] io, input logic [2:0] w);
    case (w)
      3'h2: sfe_shift = {sh[29:0], io[1:0]};
      3'h4: sfe_shift = {sh[27:0], io};
      default: sfe_shift = {sh[30:0], io[0]};
    endcase
  endfunction : sfe_shift

  // Output lines for one launch, single mode on line 1
  function automatic logic [3:0] sfe_drive(input logic [7:0] b,
      input logic [2:0] w);
    case (w)
      3'h2: sfe_drive = {2'h0, b[7:6]};
      3'h4: sfe_drive = b[7:4];
      default: sfe_drive = {2'h0, b[7], 1'b0};
    endcase
  endfunction : sfe_drive

  function automatic logic [3:0] sfe_mask(input logic [2:0] w);
    case (w)
      3'h2: sfe_mask = `SFE_OE_X2;
      3'h4: sfe_mask = `SFE_OE_X4;
      default: sfe_mask = `SFE_OE_X1;
    endcase
  endfunction : sfe_mask

  // ========
  // Pin sampling and edge detection
  logic [5:0] pin_sync;
  logic cs_prev;
  logic sclk_prev;

  sfe_sync #(.WIDTH(6), .RST_VAL(`SFE_RST_PINS)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({cs_n, sclk, quad_io_lines_in}),
    .q(pin_sync)
  );

  wire cs_s = pin_sync[5];
  wire sclk_s = pin_sync[4];
  wire [3:0] io_s = pin_sync[3:0];
  wire cs_fall = cs_prev & ~cs_s;
  wire cs_rise = cs_s & ~cs_prev;
  wire sck_rise = ~sclk_prev & sclk_s & ~cs_s;
  wire sck_fall = sclk_prev & ~sclk_s & ~cs_s;

  // Edge history
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_prev <= 1'b1;
      sclk_prev <= 1'b0;
    end else begin
      cs_prev <= cs_s;
      sclk_prev <= sclk_s;
    end
  end

  // ========
  // Protocol state
  sfe_state_type st;
  sfe_state_type next_st;
  sfe_dec_type dec_q;
  logic [7:0] opcode;
  logic [31:0] sh;
  logic [5:0] bit_cnt;
  logic [2:0] bnd_cnt;
  logic [3:0] dummy_cnt;
  logic [31:0] cmd_addr_q;
  logic [7:0] out_sr;
  logic [3:0] out_left;
  logic wide;
  logic quad;
  logic upper_seg;
  logic busy;
  logic otp;

  // Lane width of the current input phase
  wire [2:0] phase_w = (st == ST_OPC || quad) ? (quad ? 3'h4 : 3'h1) :
    (st == ST_ADDR ? dec_q.addr_w : dec_q.data_w);
  wire in_phase = st == ST_OPC || st == ST_ADDR || st == ST_WDATA;
  wire [31:0] sh_next = sfe_shift(sh, io_s, phase_w);
  wire [5:0] cnt_next = bit_cnt + {3'h0, phase_w};
  wire opc_done = st == ST_OPC && sck_rise && cnt_next == `SFE_BITS_OPC;
  wire sfe_dec_type dec_new = sfe_decode(sh_next[7:0], quad);
  wire read_blocked = dec_new.kind == K_READ && (busy | otp);
  wire long_addr = dec_q.amode == AM_LONG ||
    (dec_q.amode == AM_CFG && wide);
  wire [5:0] addr_bits = long_addr ? `SFE_BITS_ADDR4 : `SFE_BITS_ADDR3;
  wire addr_done = st == ST_ADDR && sck_rise && cnt_next == addr_bits;
  wire seg = dec_q.top | upper_seg;
  wire [31:0] addr_new = long_addr ? sh_next :
    {7'h00, seg, sh_next[`SFE_SEG_LSB-1:0]};
  wire dummy_done = st == ST_DUMMY && sck_rise &&
    dummy_cnt + 4'h1 == dec_q.dummy;
  wire exec = cs_rise && st == ST_WDATA && dec_q.kind == K_CTRL &&
    bnd_cnt == 3'h0;

  // Next state
  always_comb begin
    next_st = st;
    if (cs_s) begin
      next_st = ST_IDLE;
    end else begin
      case (st)
        ST_IDLE: if (cs_fall) next_st = ST_OPC;
        ST_OPC: begin
          if (opc_done) begin
            if (dec_new.kind == K_BAD || read_blocked) begin
              next_st = ST_STANDBY;
            end else if (dec_new.amode == AM_NONE) begin
              next_st = ST_WDATA;
            end else begin
              next_st = ST_ADDR;
            end
          end
        end
        ST_ADDR: begin
          if (addr_done) begin
            if (dec_q.kind == K_READ) begin
              next_st = dec_q.dummy == 4'h0 ? ST_RDATA : ST_DUMMY;
            end else begin
              next_st = ST_WDATA;
            end
          end
        end
        ST_DUMMY: if (dummy_done) next_st = ST_RDATA;
        ST_RDATA, ST_WDATA, ST_STANDBY: next_st = st;
        default: next_st = ST_IDLE;
      endcase
    end
  end

  // State and shift counters
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= ST_IDLE;
      sh <= 32'h0000_0000;
      bit_cnt <= 6'h00;
      bnd_cnt <= 3'h0;
      dummy_cnt <= 4'h0;
    end else begin
      st <= next_st;
      if (in_phase && sck_rise) sh <= sh_next;
      if (next_st != st) bit_cnt <= 6'h00;
      else if (sck_rise) bit_cnt <= cnt_next;
      if (st == ST_IDLE) bnd_cnt <= 3'h0;
      else if (in_phase && sck_rise) bnd_cnt <= bnd_cnt + phase_w;
      dummy_cnt <= st == ST_DUMMY ? dummy_cnt + {3'h0, sck_rise} : 4'h0;
    end
  end

  // Latched opcode and address
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dec_q <= sfe_ctl(1'b0, AM_NONE, 3'h1);
      opcode <= 8'h00;
      cmd_addr_q <= 32'h0000_0000;
    end else begin
      if (opc_done) dec_q <= dec_new;
      if (opc_done) opcode <= sh_next[7:0];
      if (addr_done) cmd_addr_q <= addr_new;
    end
  end

  // ========
  // Mode flags changed by link commands
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wide <= `SFE_RST_WIDE;
      quad <= `SFE_RST_QUAD;
    end else if (exec) begin
      case (opcode)
        `SFE_OP_ENTER_WIDE: wide <= 1'b1;
        `SFE_OP_EXIT_WIDE: wide <= 1'b0;
        `SFE_OP_ENTER_FOUR_LINE: quad <= 1'b1;
        `SFE_OP_LEAVE_FOUR_LINE: quad <= 1'b0;
        default: quad <= quad;
      endcase
    end
  end

  // Command hand-off on a clean select rise
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_valid <= 1'b0;
      cmd <= '0;
    end else begin
      cmd_valid <= exec;
      if (exec) begin
        cmd.opcode <= opcode;
        cmd.addr <= dec_q.full_erase ? 32'h0000_0000 : cmd_addr_q;
        cmd.full_erase <= dec_q.full_erase;
      end
    end
  end

  // ========
  // Read data output path
  wire [2:0] out_w = dec_q.data_w;
  wire out_load = out_left == 4'h0;
  wire [7:0] out_byte = out_load ? rd_data : out_sr;
  wire [3:0] out_base = out_load ? 4'h8 : out_left;
  wire out_stop = st != ST_RDATA || cs_s;

  // Launch bits on the falling clock edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      quad_io_lines_out <= 4'h0;
      quad_io_lines_oe <= 4'h0;
      out_sr <= 8'h00;
      out_left <= 4'h0;
    end else if (out_stop) begin
      quad_io_lines_oe <= 4'h0;
      out_left <= 4'h0;
    end else if (sck_fall) begin
      quad_io_lines_out <= sfe_drive(out_byte, out_w);
      quad_io_lines_oe <= sfe_mask(out_w);
      out_sr <= out_byte << out_w;
      out_left <= out_base - {1'b0, out_w};
    end
  end

  // Array address, advancing past segment ends
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_addr <= '0;
      rd_en <= 1'b0;
    end else begin
      rd_en <= next_st == ST_RDATA;
      if (addr_done && dec_q.kind == K_READ) begin
        rd_addr <= addr_new[ADDR_W-1:0];
      end else if (!out_stop && sck_fall && out_load) begin
        rd_addr <= rd_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ========
  // Avalon-MM slave
  wire bus_req = avs_read | avs_write;
  wire bus_commit = avs_write & ~avs_waitrequest;
  wire sel_ctrl = avs_address == `SFE_OFS_CTRL;
  wire sel_upper = avs_address == `SFE_OFS_UPPER;
  wire sel_status = avs_address == `SFE_OFS_STATUS;
  wire lane0_wr = bus_commit & avs_byteenable[0];
  wire active = st != ST_IDLE && st != ST_STANDBY;
  logic [31:0] ctrl_word;
  logic [31:0] upper_word;
  logic [31:0] status_word;

  // Read views, reserved bits zero
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[`SFE_CTRL_BUSY] = busy;
    ctrl_word[`SFE_CTRL_OTP] = otp;
    upper_word = 32'h0000_0000;
    upper_word[`SFE_UPPER_SEG] = upper_seg;
    status_word = 32'h0000_0000;
    status_word[`SFE_ST_WIDE] = wide;
    status_word[`SFE_ST_QUAD] = quad;
    status_word[`SFE_ST_ACTIVE] = active;
    status_word[`SFE_ST_STANDBY] = st == ST_STANDBY;
    status_word[`SFE_ST_OPC] = opcode;
  end

  wire [31:0] rd_mux = sel_ctrl ? ctrl_word :
    sel_upper ? upper_word : sel_status ? status_word : 32'h0000_0000;

  // One wait cycle, then the answer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (avs_read && avs_waitrequest) avs_readdata <= rd_mux;
    end
  end

  // Software registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      upper_seg <= `SFE_RST_UPPER;
      busy <= 1'b0;
      otp <= 1'b0;
    end else begin
      if (lane0_wr && sel_upper) upper_seg <= avs_writedata[0];
      if (lane0_wr && sel_ctrl) busy <= avs_writedata[`SFE_CTRL_BUSY];
      if (lane0_wr && sel_ctrl) otp <= avs_writedata[`SFE_CTRL_OTP];
    end
  end
endmodule : sfe_front_end

// ---- verif/sfe_front_end_monitor.sv ----
// Port checker for the flash command front end
module sfe_monitor import sfe_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] quad_io_lines_out,
  input wire logic [3:0] quad_io_lines_oe,
  // Register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Command port
  input wire logic cmd_valid,
  input wire sfe_cmd_type cmd
);
  // ========
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no bus answer");
  a_bus_release: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("long bus answer");
  a_upper_zero: assert property (
    avs_read && avs_waitrequest && avs_address == 4'h4
    |=> avs_readdata[31:1] == 31'h0000_0000)
    else $error("upper bits set");
  a_cs_quiet: assert property (
    cs_n [*6] |-> quad_io_lines_oe == 4'h0)
    else $error("driven while idle");
  a_launch_fall: assert property (
    $changed(quad_io_lines_out) && quad_io_lines_oe != 4'h0 |-> !sclk)
    else $error("launch in high phase");
  a_cmd_pulse: assert property (
    cmd_valid |=> !cmd_valid)
    else $error("long command pulse");
  a_cmd_after_cs: assert property (
    cmd_valid |-> cs_n && $past(cs_n, 2))
    else $error("command before select");
  a_erase_whole: assert property (
    cmd_valid && cmd.full_erase
    |-> cmd.addr == 32'h0000_0000 && cmd.opcode inside {8'h60, 8'hc7})
    else $error("erase not whole");
  c_erase: cover property (cmd_valid && cmd.full_erase);
  c_quad_out: cover property (quad_io_lines_oe == 4'hf);
  c_bus_write: cover property (!avs_waitrequest && avs_write);
endmodule : sfe_monitor

bind sfe_front_end sfe_monitor i_mon (.clk, .sys_rst,
  .cs_n, .sclk, .quad_io_lines_out, .quad_io_lines_oe, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .cmd_valid,
  .cmd);

// ---- verif/sfe_host_model.sv ----
// Host flash controller model driving the link pins
module sfe_host_model (
  // Clock
  input wire logic clk,
  // Link pins
  output logic cs_n,
  output logic sclk,
  output logic [3:0] io_drv,
  output logic [3:0] io_en,
  input wire logic [3:0] io_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic idle_hi;
  // Pins idle deselected
  initial begin
    {cs_n, sclk, io_drv, io_en, idle_hi} = 11'h400;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // Clock parks at its idle level before select falls
  task automatic open_frame(input logic hi);
    idle_hi = hi;
    tick(1);
    sclk <= hi;
    tick(4);
    cs_n <= 1'b0;
    tick(4);
  endtask : open_frame
  // Select rises after whole units only, clock back at idle
  task automatic close_frame();
    tick(1);
    sclk <= idle_hi;
    io_en <= 4'h0;
    tick(3);
    cs_n <= 1'b1;
    tick(8);
  endtask : close_frame
  // Shift n bits over w lines: drive in low phase, sample at rise
  task automatic shift(input logic [31:0] val, input int n, input int w,
      input logic drv, output logic [31:0] got);
    logic [3:0] m;
    m = 4'((1 << w) - 1);
    got = '0;
    for (int i = n; i > 0; i -= w) begin
      tick(1);
      sclk <= 1'b0;
      io_drv <= 4'(val >> (i - w)) & m;
      io_en <= drv ? m : 4'h0;
      tick(5);
      got = (got << w) | 32'((w == 1) ? {3'h0, io_seen[1]} : io_seen & m);
      sclk <= 1'b1;
      tick(2);
    end
  endtask : shift
endmodule : sfe_host_model

// ---- verif/test_sfe_front_end.sv ----
// Self-checking bench for the flash command front end
`include "sfe_map.svh"
module test_sfe_front_end import sfe_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, sys_rst, cs_n, sclk, pat, avs_read, avs_write;
  logic avs_waitrequest, rd_en, cmd_valid;
  logic [3:0] h_drv, h_en, lines, io_out, io_oe, avs_address, avs_be;
  logic [31:0] avs_writedata, avs_readdata;
  logic [24:0] rd_addr;
  logic [7:0] rd_data;
  sfe_cmd_type cmd, last_cmd;
  int errors, tests_run, n_cmd;
  // Array image and wire levels; a loose line toggles each cycle
  function automatic logic [7:0] exp_byte(input logic [24:0] a);
    return a[7:0] + {a[24], a[14:8]};
  endfunction : exp_byte
  assign rd_data = exp_byte(rd_addr);
  assign lines = (io_oe & io_out) | (~io_oe & h_en & h_drv)
    | (~io_oe & ~h_en & {4{pat}});
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Loose-line pattern and command capture
  always @(posedge clk) begin
    pat <= ~pat;
    if (cmd_valid === 1'b1) begin
      last_cmd <= cmd;
      n_cmd <= n_cmd + 1;
    end
  end
  sfe_front_end i_dut (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n),
    .sclk(sclk), .quad_io_lines_in(lines), .quad_io_lines_out(io_out),
    .quad_io_lines_oe(io_oe), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_be),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rd_addr(rd_addr), .rd_en(rd_en), .rd_data(rd_data),
    .cmd_valid(cmd_valid), .cmd(cmd));
  sfe_host_model i_host (.clk(clk), .cs_n(cs_n), .sclk(sclk),
    .io_drv(h_drv), .io_en(h_en), .io_seen(lines));
  // ========
  // Shared tasks
  task automatic give_verdict();
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Bus transfer held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      errors++;
      give_verdict();
    end
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  // Register read compared under a mask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp,
      input logic [31:0] m = '1);
    logic [31:0] q;
    bus(1'b0, a, '0, q);
    check("register", exp, q & m);
  endtask : rd_chk
  task automatic ctrl(input logic [31:0] v, input int n, input int w);
    logic [31:0] g;
    i_host.open_frame(1'b0);
    i_host.shift(v, n, w, 1'b1, g);
    i_host.close_frame();
  endtask : ctrl
  // Read nb bytes and compare with the array image from ea on
  task automatic rdx(input logic [7:0] op, input int ow, input logic [31:0] a,
      input int ab, aw, dm, dw, nb, input logic [24:0] ea, input logic hi);
    logic [31:0] g;
    i_host.open_frame(hi);
    i_host.shift(32'(op), 8, ow, 1'b1, g);
    i_host.shift(a, ab, aw, 1'b1, g);
    if (dm > 0) i_host.shift('0, dm, 1, 1'b0, g);
    for (int i = 0; i < nb; i++) begin
      i_host.shift('0, 8, dw, 1'b0, g);
      check("read data", 32'(exp_byte(ea + 25'(i))), g);
    end
    i_host.close_frame();
  endtask : rdx
  // Opcode followed by clocks; device must stay off the lines
  task automatic refused(input logic [7:0] op, input int w);
    logic [31:0] g;
    i_host.open_frame(1'b0);
    i_host.shift(32'(op), 8, w, 1'b1, g);
    i_host.shift(32'h100, 32, w, 1'b1, g);
    i_host.shift('0, 16, 1, 1'b0, g);
    check("line enables", '0, 32'(io_oe));
    rd_chk(`SFE_OFS_STATUS, 32'h8, 32'hc);
    i_host.close_frame();
  endtask : refused
  // ========
  // Scenarios
  task automatic t_regs();
    rd_chk(`SFE_OFS_UPPER, 32'h0000_0000);
    rd_chk(`SFE_OFS_STATUS, 32'h0000_0000);
    wr(`SFE_OFS_UPPER, 32'hffff_ffff);
    rd_chk(`SFE_OFS_UPPER, 32'h0000_0001);
    wr(4'hc, 32'hffff_ffff);
    rd_chk(4'hc, 32'h0000_0000);
    wr(`SFE_OFS_UPPER, 32'h0000_0000);
  endtask : t_regs
  task automatic t_reads();
    logic [7:0] ops[5] = '{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb};
    int aws[5] = '{1, 1, 1, 1, 2};
    int dms[5] = '{0, 8, 8, 8, 4};
    int dws[5] = '{1, 1, 2, 4, 2};
    for (int i = 0; i < 5; i++) begin
      rdx(ops[i], 1, 32'h0012_3400, 24, aws[i], dms[i], dws[i], 2,
        25'h012_3400, 1'b0);
    end
  endtask : t_reads
  task automatic t_segment();
    rdx(8'h03, 1, 32'h00ff_ffff, 24, 1, 0, 1, 2, 25'h0ff_ffff, 1'b0);
    rd_chk(`SFE_OFS_UPPER, 32'h0000_0000);
    wr(`SFE_OFS_UPPER, 32'h0000_0001);
    rdx(8'h03, 1, 32'h0000_0010, 24, 1, 0, 1, 1, 25'h100_0010, 1'b1);
  endtask : t_segment
  task automatic t_wide();
    ctrl(32'h0000_00b7, 8, 1);
    rd_chk(`SFE_OFS_STATUS, 32'h1, 32'h3);
    rdx(8'h03, 1, 32'h0000_0020, 32, 1, 0, 1, 1, 25'h000_0020, 1'b0);
    rdx(8'h03, 1, 32'h0100_0040, 32, 1, 0, 1, 1, 25'h100_0040, 1'b0);
    ctrl(32'h0000_00e9, 8, 1);
    rd_chk(`SFE_OFS_STATUS, 32'h0, 32'h3);
    rdx(8'h13, 1, 32'h00ff_fff0, 32, 1, 0, 1, 1, 25'h0ff_fff0, 1'b0);
    ctrl(32'h0000_016e, 9, 1);
    rd_chk(`SFE_OFS_STATUS, 32'h0, 32'h3);
  endtask : t_wide
  task automatic t_erase();
    logic [7:0] ops[2] = '{8'h60, 8'hc7};
    int n0;
    foreach (ops[i]) begin
      n0 = n_cmd;
      ctrl(32'(ops[i]), 8, 1);
      check("command count", 32'(n0 + 1), 32'(n_cmd));
      check("erase", {23'h0, 1'b1, ops[i]},
        {23'h0, last_cmd.full_erase, last_cmd.opcode});
      check("erase addr", 32'h0000_0000, last_cmd.addr);
    end
  endtask : t_erase
  task automatic t_quad();
    wr(`SFE_OFS_UPPER, 32'h0000_0000);
    rdx(8'heb, 1, 32'h0000_0200, 24, 4, 6, 4, 1, 25'h000_0200, 1'b0);
    ctrl(32'h0000_0035, 8, 1);
    rd_chk(`SFE_OFS_STATUS, 32'h2, 32'h3);
    rdx(8'heb, 4, 32'h0000_0200, 24, 4, 6, 4, 2, 25'h000_0200, 1'b0);
    rdx(8'hea, 4, 32'h0000_0300, 24, 4, 6, 4, 1, 25'h100_0300, 1'b0);
    refused(8'h03, 4);
    ctrl(32'h0000_00f5, 8, 4);
    rd_chk(`SFE_OFS_STATUS, 32'h0, 32'h3);
  endtask : t_quad
  task automatic t_refuse();
    refused(8'hff, 1);
    for (int b = 0; b < 2; b++) begin
      wr(`SFE_OFS_CTRL, 32'(1 << b));
      refused(8'h03, 1);
    end
    wr(`SFE_OFS_CTRL, 32'h0000_0000);
  endtask : t_refuse
  task automatic t_abort();
    logic [31:0] g;
    i_host.open_frame(1'b0);
    i_host.shift(32'h0000_0003, 8, 1, 1'b1, g);
    i_host.shift(32'h0000_0400, 24, 1, 1'b1, g);
    i_host.shift('0, 3, 1, 1'b0, g);
    rd_chk(`SFE_OFS_STATUS, 32'h4, 32'hc);
    i_host.close_frame();
    check("line enables", '0, 32'(io_oe));
    rdx(8'h03, 1, 32'h0000_0400, 24, 1, 0, 1, 1, 25'h000_0400, 1'b0);
  endtask : t_abort
  // ========
  // Main sequence and hang guard
  initial begin
    {sys_rst, avs_read, avs_write, pat, avs_be} = 8'h8f;
    {avs_address, avs_writedata} = '0;
    {n_cmd, errors, tests_run} = '0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_regs();
    t_reads();
    t_segment();
    t_wide();
    t_erase();
    t_quad();
    t_refuse();
    t_abort();
    give_verdict();
  end
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    give_verdict();
  end
endmodule : test_sfe_front_end
